// ### design/chp_cfg.svh
// constants for the calculator host command port
`ifndef CHP_CFG_SVH
`define CHP_CFG_SVH
`define CHP_CMD_RESET    8'h00
`define CHP_SEL_LSB      0
`define CHP_KEY_LSB      4
`define CHP_DIGITS       9
`define CHP_KEYS         4
`endif

// ### design/chp_pkg.sv
// types for the calculator host command port
package chp_pkg;
  typedef enum logic [2:0] {
    CHP_IDLE  = 3'b001,
    CHP_PRESS = 3'b010,
    CHP_BUSY  = 3'b100
  } chp_state_t;
endpackage

// ### design/chp_sync.sv
// three-stage synchroniser bank with agreement filter
`timescale 1ns/1ps
module chp_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
    logic [WIDTH-1:0] s3;
    logic [WIDTH-1:0] q;
  } chp_sync_st_t;
  chp_sync_st_t st;
  chp_sync_st_t next_st;

  initial begin
    if (WIDTH < 1) $error("chp_sync width must be positive");
  end

  // first stage feeds only the second; a change counts once stages two and three agree
  always_comb begin
    next_st    = st;
    next_st.s1 = din;
    next_st.s2 = st.s1;
    next_st.s3 = st.s2;
    for (int i = 0; i < WIDTH; i++) begin
      if (st.s2[i] == st.s3[i]) begin
        next_st.q[i] = st.s3[i];
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign dout = st.q;
endmodule

// ### design/chp_port.sv
// host command port: command register, digit mux, key gating, readback
`timescale 1ns/1ps
`include "chp_cfg.svh"

// Overview of operation
// - the host writes an 8-bit command whose low nibble picks one of nine digit strobes.
// - the high nibble of the stored command gates the picked strobe onto the key inputs.
// - when ready falls on acceptance the command register clears and the host sees ready as acceptance.
// - during readback the mux output asserts when the picked digit strobe occurs.
// - the host halts after loading a digit code, the mux output resumes it, and it then reads at once.
// - segments a to g and the decimal point go to the host bus as one byte on a read.
// - the calculator holds ready low from key processing until function done and key release timed out.
// - the calculator accepts key closure and release only after a noise-free timeout.
module chp_port #(
  parameter int DIGITS = `CHP_DIGITS
) (
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  input  wire logic              host_wr,
  input  wire logic [7:0]        host_wdata,
  input  wire logic              host_rd,
  output logic      [7:0]        host_rdata,
  output logic                   host_accept,
  output logic                   host_resume,
  input  wire logic [DIGITS-1:0] calc_digit,
  input  wire logic [7:0]        calc_seg,
  input  wire logic              calc_ready,
  output logic      [3:0]        calc_key
);
  typedef struct packed {
    logic [7:0]        cmd;
    chp_pkg::chp_state_t state;
    logic [7:0]        rdata;
    logic              accept;
    logic              resume;
    logic [3:0]        key;
    logic              rdy_q;
  } chp_st_t;
  chp_st_t st;
  chp_st_t next_st;

  logic [DIGITS-1:0] dig_s;
  logic [7:0]        seg_s;
  logic              rdy_s;
  logic [3:0]        sel;
  logic              strobe;

  initial begin
    if (DIGITS < 1 || DIGITS > 16) $error("chp_port digits must be 1 to 16");
  end

  // pins from the calculator come from another domain; key debounce stays in the calculator
  chp_sync #(.WIDTH(DIGITS + 9)) u_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .din     ({calc_ready, calc_seg, calc_digit}),
    .dout    ({rdy_s, seg_s, dig_s})
  );

  // digit select; codes beyond the last digit give no strobe
  assign sel = st.cmd[`CHP_SEL_LSB +: 4];
  always_comb begin
    strobe = 1'b0;
    for (int i = 0; i < DIGITS; i++) begin
      if (sel == 4'(i)) begin
        strobe = dig_s[i];
      end
    end
  end

  // command register, key emulation and readback
  always_comb begin
    next_st        = st;
    next_st.rdy_q  = rdy_s;
    next_st.accept = 1'b0;
    next_st.key    = st.cmd[`CHP_KEY_LSB +: 4] & {4{strobe}};
    next_st.resume = strobe && (st.cmd[`CHP_KEY_LSB +: 4] == 4'h0) && (st.state == chp_pkg::CHP_PRESS);
    if (host_rd) begin
      next_st.rdata = seg_s;
    end
    case (st.state)
      chp_pkg::CHP_IDLE: begin
        // writes while busy are ignored, the host must wait for ready
        if (host_wr) begin
          next_st.cmd   = host_wdata;
          next_st.state = chp_pkg::CHP_PRESS;
        end
      end
      chp_pkg::CHP_PRESS: begin
        // hold the command so the key stays closed through debounce
        if (st.rdy_q && !rdy_s) begin
          next_st.cmd    = `CHP_CMD_RESET;
          next_st.key    = 4'h0;
          next_st.accept = 1'b1;
          next_st.state  = chp_pkg::CHP_BUSY;
        end else if (host_wr && st.cmd[`CHP_KEY_LSB +: 4] == 4'h0) begin
          next_st.cmd = host_wdata; // a readback may be retargeted
        end
      end
      chp_pkg::CHP_BUSY: begin
        if (rdy_s) begin
          next_st.state = chp_pkg::CHP_IDLE;
        end
      end
      default: begin
        next_st.state = chp_pkg::CHP_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      st       <= '0;
      st.state <= chp_pkg::CHP_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign host_rdata  = st.rdata;
  assign host_accept = st.accept;
  assign host_resume = st.resume;
  assign calc_key    = st.key;

  AST_CLEAR_ON_READY: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st.state == chp_pkg::CHP_PRESS && st.rdy_q && !rdy_s) |=> (st.cmd == 8'h00 && host_accept))
    else $error("command not cleared on ready fall");
  AST_HOLD_CMD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st.state == chp_pkg::CHP_PRESS && st.cmd[7:4] != 4'h0 && !(st.rdy_q && !rdy_s)) |=> $stable(st.cmd))
    else $error("command changed before acceptance");
  AST_KEY_GATE: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st.state == chp_pkg::CHP_PRESS && strobe && !(st.rdy_q && !rdy_s)) |=> (calc_key == $past(st.cmd[7:4])))
    else $error("key not gated from strobe");
  AST_RESUME: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st.state == chp_pkg::CHP_PRESS && strobe && st.cmd[7:4] == 4'h0) |=> host_resume)
    else $error("resume missing on selected strobe");
  AST_NO_KEY_READ: assert property (@(posedge clk_sys) disable iff (!rst_b)
    host_resume |-> calc_key == 4'h0)
    else $error("key emulated during readback");
  AST_READ_DATA: assert property (@(posedge clk_sys) disable iff (!rst_b)
    host_rd |=> host_rdata == $past(seg_s))
    else $error("read data not the segment byte");
  AST_WRITE_LOAD: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st.state == chp_pkg::CHP_IDLE && host_wr) |=> (st.cmd == $past(host_wdata) && st.state == chp_pkg::CHP_PRESS))
    else $error("command not loaded");
  AST_BUSY_EXIT: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (st.state == chp_pkg::CHP_BUSY && !rdy_s) |=> st.state == chp_pkg::CHP_BUSY)
    else $error("left busy while ready low");
endmodule

// ### test/chp_calc_model.sv
// calculator model: digit scan, segments, debounced keys and ready
`timescale 1ns/1ps
module chp_calc_model (
  input  wire logic [3:0] calc_key,
  input  wire logic       clk_sys,
  output logic      [8:0] calc_digit,
  output logic      [7:0] calc_seg,
  output logic            calc_ready,
  output logic      [3:0] seen_key
);
  localparam logic [7:0] SEG [9] = '{8'h3f, 8'h06, 8'h5b, 8'h4f, 8'h66, 8'h6d, 8'h7d, 8'h07, 8'h7f};
  int idx = 0, sub = 0, deb = 0, rel = 0;
  initial calc_ready = 1'b1;
  initial seen_key = 4'h0;
  // digit 3 shows its point so bit 7 travels too
  function automatic logic [7:0] seg_of(input int d);
    return SEG[d] | ((d == 3) ? 8'h80 : 8'h00);
  endfunction
  // any gap in the key restarts the run, so one glitch cannot enter a key
  always @(posedge clk_sys) begin
    sub = (sub + 1) % 8;
    if (sub == 0) idx = (idx + 1) % 9;
    if (calc_key != 4'h0) deb++; else deb = 0;
    if (calc_key == 4'h0) rel++; else rel = 0;
    if (calc_ready && deb == 3) begin
      calc_ready <= 1'b0;
      seen_key <= calc_key;
    end else if (!calc_ready && rel == 80) calc_ready <= 1'b1;
  end
  assign calc_digit = 9'h001 << idx;
  assign calc_seg = seg_of(idx);
endmodule

// ### test/tb.sv
// self-checking bench for the calculator host command port
`timescale 1ns/1ps
module tb;
  logic       clk_sys = 0, rst_b = 0, host_wr = 0, host_rd = 0, rd_d = 0;
  logic [7:0] host_wdata = 8'h00, host_rdata, calc_seg, exp_q [$];
  logic       host_accept, host_resume, calc_ready;
  logic [8:0] calc_digit;
  logic [3:0] calc_key, seen_key, key;
  int         n_mismatch = 0, checks = 0, d;
  always #25 clk_sys = ~clk_sys;
  chp_port uut (.clk_sys(clk_sys), .rst_b(rst_b), .host_wr(host_wr), .host_wdata(host_wdata),
    .host_rd(host_rd), .host_rdata(host_rdata), .host_accept(host_accept), .host_resume(host_resume),
    .calc_digit(calc_digit), .calc_seg(calc_seg), .calc_ready(calc_ready), .calc_key(calc_key));
  chp_calc_model u_calc (.calc_key(calc_key), .clk_sys(clk_sys), .calc_digit(calc_digit),
    .calc_seg(calc_seg), .calc_ready(calc_ready), .seen_key(seen_key));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // bounded wait: 0 accept, 1 resume, 2 ready back high
  task automatic wait_hi(input int w);
    int n;
    n = 0;
    while ((w == 0 ? host_accept : w == 1 ? host_resume : calc_ready) !== 1'b1) begin
      @(negedge clk_sys);
      n++;
      if (n > 400) begin
        n_mismatch++;
        $display("ERROR t=%0t wait %h exp %h", $time, w, 1);
        end_of_test();
      end
    end
  endtask
  task automatic put(input logic [7:0] w);
    @(negedge clk_sys);
    host_wr = 1;
    host_wdata = w;
    @(negedge clk_sys);
    host_wr = 0;
  endtask
  // results are matched against the oldest note when they appear
  always @(posedge clk_sys) begin
    rd_d <= host_rd;
    if (host_accept === 1'b1) chk({4'h0, seen_key}, exp_q.pop_front());
    if (rd_d) chk(host_rdata, exp_q.pop_front());
  end
  initial begin
    void'($urandom(72));
    repeat (8) @(negedge clk_sys);
    rst_b = 1;
    // every digit read back, pending readback never presses a key
    for (int i = 0; i < 9; i++) begin
      put({4'h0, 4'(i)});
      // resume seen at the write edge still belongs to the old digit
      @(negedge clk_sys);
      wait_hi(1);
      exp_q.push_back(u_calc.seg_of(i));
      @(negedge clk_sys);
      host_rd = 1;
      @(negedge clk_sys);
      host_rd = 0;
      chk({4'h0, calc_key}, 8'h00);
    end
    // each key line alone, then random key sets on random digits
    for (int k = 0; k < 8; k++) begin
      d = $urandom % 9;
      key = (k < 4) ? (4'h1 << k) : 4'($urandom % 15 + 1);
      exp_q.push_back({4'h0, key});
      put({key, 4'(d)});
      wait_hi(0);
      @(negedge clk_sys);
      chk({4'h0, calc_key}, 8'h00);
      wait_hi(2);
      // the port leaves busy only once its synchronised ready is high
      repeat (6) @(negedge clk_sys);
    end
    repeat (4) @(negedge clk_sys);
    end_of_test();
  end
endmodule
